//--- include/sensor_pkg.sv
// Shared constants, register map and carrier types for the sensor readout block
package sensor_pkg;

    // Bit slots per pixel period; one slot is one clock_i cycle
    localparam logic [3:0] LAST_SLOT = 4'hB;

    // Serial register port framing
    localparam logic [3:0] LAST_ADDR_BIT = 4'h7;
    localparam logic [3:0] LAST_GROUP_BIT = 4'hF;

    // Register addresses (7-bit)
    localparam logic [6:0] ROWS_LO_ADDR = 7'h01;
    localparam logic [6:0] ROWS_HI_ADDR = 7'h02;
    localparam logic [6:0] FRAMES_LO_ADDR = 7'h16;
    localparam logic [6:0] FRAMES_HI_ADDR = 7'h17;
    localparam logic [6:0] EXP_LO_ADDR = 7'h20;
    localparam logic [6:0] EXP_HI_ADDR = 7'h21;
    localparam logic [6:0] LANE_MODE_ADDR = 7'h50;
    localparam logic [6:0] EXP_SRC_ADDR = 7'h51;
    localparam logic [6:0] TRAIN_LO_ADDR = 7'h5A;
    localparam logic [6:0] TRAIN_HI_ADDR = 7'h5B;
    localparam logic [6:0] LANE_PD0_ADDR = 7'h5F;
    localparam logic [6:0] LANE_PD1_ADDR = 7'h60;
    localparam logic [6:0] LANE_PD2_ADDR = 7'h61;
    localparam logic [6:0] PART_FIRST_ADDR = 7'h67;
    localparam logic [6:0] STATUS_ADDR = 7'h68;
    localparam logic [6:0] PART_LAST_ADDR = 7'h7E;

    // Field positions
    localparam int LANE8_BIT = 0;
    localparam int EXT_EXP_BIT = 0;

    // Values after reset
    localparam logic [15:0] FRAMES_RST = 16'h0001;
    localparam logic [15:0] EXP_RST = 16'h0F00;
    localparam logic [15:0] ROWS_RST = 16'h0F00;
    localparam logic [11:0] TRAIN_RST = 12'h055;

    // Readout timing in pixel periods
    localparam logic [9:0] BURST_PIX = 10'h280;
    localparam logic [9:0] OVERHEAD_PIX = 10'h008;

    // Readout sequencer states
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_OVERHEAD = 3'b010,
        RD_ROWS = 3'b100
    } rd_state_t;

    // Exposure sequencer states
    typedef enum logic [2:0] {
        EX_IDLE = 3'b001,
        EX_RUN = 3'b010,
        EX_HOLD = 3'b100
    } ex_state_t;

    // One decoded register write from the serial port
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // Control lane status word, bit 11 down to bit 0
    typedef struct packed {
        logic [1:0] zero_hi;
        logic one;
        logic zero_mid;
        logic inte2;
        logic inte1;
        logic overhead;
        logic [1:0] zero_lo;
        logic frame_valid;
        logic row_valid;
        logic pixel_valid;
    } ctrl_word_t;

endpackage

//--- rtl/serial_reg_port.sv
// Five-wire serial register port: write decode and dual readback shifter
`timescale 1ns/1ns
module serial_reg_port
    import sensor_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic sel_i,
    input wire logic sdi_i,
    input wire logic [7:0] rd_full_i,
    input wire logic [7:0] rd_part_i,
    output reg_write_t wr_o,
    output logic [6:0] rd_addr_o,
    output logic out_full_o,
    output logic out_part_o
);

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic sclk_prev_q;
    logic [15:0] sh_q;
    logic [3:0] cnt_q;
    logic load_pend_q;
    logic [6:0] full_sh_q;
    logic [6:0] part_sh_q;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_s;
    logic sdi_s;

    // Two-stage synchronisers for clock, select and data pins
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            meta_q <= {sclk_i, sel_i, sdi_i};
            sync_q <= meta_q;
            sclk_prev_q <= sync_q[2];
        end
    end

    assign sel_s = sync_q[1];
    assign sdi_s = sync_q[0];
    assign sclk_rise = sync_q[2] & ~sclk_prev_q;
    assign sclk_fall = ~sync_q[2] & sclk_prev_q;

    // Input shifter; bit count wraps so bursts decode group by group
    always_ff @(posedge clock_i) begin
        if (srst_i || !sel_s) begin
            sh_q <= 16'h0000;
            cnt_q <= 4'h0;
            wr_o <= '0;
            rd_addr_o <= 7'h00;
            load_pend_q <= 1'b0;
        end else begin
            wr_o.valid <= 1'b0;
            if (sclk_rise) begin
                sh_q <= {sh_q[14:0], sdi_s};
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == LAST_ADDR_BIT) begin
                    rd_addr_o <= {sh_q[5:0], sdi_s};
                    load_pend_q <= ~sh_q[6];
                end
                if (cnt_q == LAST_GROUP_BIT && sh_q[14]) begin
                    wr_o.valid <= 1'b1;
                    wr_o.addr <= sh_q[13:7];
                    wr_o.data <= {sh_q[6:0], sdi_s};
                end
            end else if (sclk_fall) begin
                load_pend_q <= 1'b0;
            end
        end
    end

    // Readback launch on falling edges, MSB first, both outputs in step
    always_ff @(posedge clock_i) begin
        if (srst_i || !sel_s) begin
            out_full_o <= 1'b0;
            out_part_o <= 1'b0;
            full_sh_q <= 7'h00;
            part_sh_q <= 7'h00;
        end else if (sclk_fall) begin
            if (load_pend_q) begin
                out_full_o <= rd_full_i[7];
                out_part_o <= rd_part_i[7];
                full_sh_q <= rd_full_i[6:0];
                part_sh_q <= rd_part_i[6:0];
            end else begin
                out_full_o <= full_sh_q[6];
                out_part_o <= part_sh_q[6];
                full_sh_q <= {full_sh_q[5:0], 1'b0};
                part_sh_q <= {part_sh_q[5:0], 1'b0};
            end
        end
    end

endmodule

//--- rtl/sensor_readout.sv
// Sensor control and readout: registers, exposure sequencing, lane serialiser
`timescale 1ns/1ns
module sensor_readout
    import sensor_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic spi_clk_i,
    input wire logic spi_sel_i,
    input wire logic spi_in_i,
    output logic spi_out_full_o,
    output logic spi_out_part_o,
    input wire logic frame_request_i,
    input wire logic exposure_trigger_i,
    output logic [15:0] data_lane_o,
    output logic control_lane_o,
    output logic clock_lane_o
);

    logic [7:0] reg_q [0:127];
    reg_write_t wr;
    logic [6:0] rd_addr;
    logic [7:0] rd_full;
    logic [7:0] rd_part;
    logic [7:0] status;

    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic [1:0] pin_prev_q;
    logic req_rise;
    logic trig_rise;

    logic [3:0] slot_q;
    logic pix_en;
    logic load_en;

    ex_state_t ex_state_q;
    logic [15:0] exp_cnt_q;
    logic [15:0] frames_left_q;
    rd_state_t rd_state_q;
    logic [9:0] ovh_cnt_q;
    logic [9:0] pix_q;
    logic [15:0] burst_q;
    logic rd_last;
    logic rd_start;

    logic [15:0] frames_cfg;
    logic [15:0] exp_len;
    logic [15:0] rows_cfg;
    logic [15:0] bursts_total;
    logic [11:0] train_word;
    logic [7:0] top_lane_off;
    logic lane8;
    logic ext_mode;

    logic [11:0] lane_sh_q [0:15];
    logic [11:0] ctrl_sh_q;
    ctrl_word_t ctrl_word;

    // Value of each register after reset
    function automatic logic [7:0] reg_default(input logic [6:0] a);
        case (a)
            FRAMES_LO_ADDR: reg_default = FRAMES_RST[7:0];
            FRAMES_HI_ADDR: reg_default = FRAMES_RST[15:8];
            EXP_LO_ADDR: reg_default = EXP_RST[7:0];
            EXP_HI_ADDR: reg_default = EXP_RST[15:8];
            ROWS_LO_ADDR: reg_default = ROWS_RST[7:0];
            ROWS_HI_ADDR: reg_default = ROWS_RST[15:8];
            TRAIN_LO_ADDR: reg_default = TRAIN_RST[7:0];
            TRAIN_HI_ADDR: reg_default = {4'h0, TRAIN_RST[11:8]};
            default: reg_default = 8'h00;
        endcase
    endfunction

    // Joins a low and high register into a 16-bit field
    function automatic logic [15:0] reg_pair(input logic [7:0] lo, input logic [7:0] hi);
        reg_pair = {hi, lo};
    endfunction

    serial_reg_port u_port (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .sclk_i(spi_clk_i),
        .sel_i(spi_sel_i),
        .sdi_i(spi_in_i),
        .rd_full_i(rd_full),
        .rd_part_i(rd_part),
        .wr_o(wr),
        .rd_addr_o(rd_addr),
        .out_full_o(spi_out_full_o),
        .out_part_o(spi_out_part_o)
    );

    // Register file; writes come only from the serial port
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            for (int i = 0; i < 128; i++) begin
                reg_q[i] <= reg_default(7'(i));
            end
        end else if (wr.valid) begin
            reg_q[wr.addr] <= wr.data;
        end
    end

    // Readback: status register shows live sequencer state
    assign status = {2'h0, rd_state_q, ex_state_q};
    assign rd_full = (rd_addr == STATUS_ADDR) ? status : reg_q[rd_addr];
    assign rd_part = (rd_addr >= PART_FIRST_ADDR && rd_addr <= PART_LAST_ADDR)
                     ? rd_full : 8'h00;

    // Configuration fields
    assign frames_cfg = reg_pair(reg_q[FRAMES_LO_ADDR], reg_q[FRAMES_HI_ADDR]);
    assign exp_len = reg_pair(reg_q[EXP_LO_ADDR], reg_q[EXP_HI_ADDR]);
    assign rows_cfg = reg_pair(reg_q[ROWS_LO_ADDR], reg_q[ROWS_HI_ADDR]);
    assign train_word = {reg_q[TRAIN_HI_ADDR][3:0], reg_q[TRAIN_LO_ADDR]};
    assign lane8 = reg_q[LANE_MODE_ADDR][LANE8_BIT];
    assign ext_mode = reg_q[EXP_SRC_ADDR][EXT_EXP_BIT];
    assign top_lane_off = reg_q[LANE_PD0_ADDR];
    // Two rows per burst in 16-lane mode; an odd last row still gets a burst
    assign bursts_total = lane8 ? rows_cfg
                          : 16'((17'(rows_cfg) + 17'h00001) >> 1);

    // Request and trigger synchronisers; edges taken from the second stage
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pin_meta_q <= 2'h0;
            pin_sync_q <= 2'h0;
            pin_prev_q <= 2'h0;
        end else begin
            pin_meta_q <= {frame_request_i, exposure_trigger_i};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign req_rise = pin_sync_q[1] & ~pin_prev_q[1];
    assign trig_rise = pin_sync_q[0] & ~pin_prev_q[0];

    // Bit slot divider: twelve slots make one pixel period
    always_ff @(posedge clock_i) begin
        if (srst_i || pix_en) begin
            slot_q <= 4'h0;
        end else begin
            slot_q <= slot_q + 4'h1;
        end
    end

    assign pix_en = (slot_q == LAST_SLOT);
    assign load_en = (slot_q == 4'h0);

    // Readout accepts a finished exposure when idle or just finishing a frame
    assign rd_last = (rd_state_q == RD_ROWS) && (pix_q == BURST_PIX)
                     && (burst_q + 16'h0001 >= bursts_total);
    assign rd_start = pix_en && (ex_state_q == EX_HOLD)
                      && (rd_state_q == RD_IDLE || rd_last);

    // Exposure sequencer; a new request is ignored while frames remain
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ex_state_q <= EX_IDLE;
            exp_cnt_q <= 16'h0000;
            frames_left_q <= 16'h0000;
        end else begin
            case (ex_state_q)
                EX_IDLE: begin
                    if (!ext_mode && req_rise && frames_left_q == 16'h0000) begin
                        frames_left_q <= frames_cfg;
                        exp_cnt_q <= exp_len;
                        ex_state_q <= EX_RUN;
                    end else if (ext_mode && trig_rise) begin
                        ex_state_q <= EX_RUN;
                    end
                end
                EX_RUN: begin
                    if (ext_mode) begin
                        if (req_rise) begin
                            ex_state_q <= EX_HOLD;
                        end
                    end else if (pix_en) begin
                        if (exp_cnt_q <= 16'h0001) begin
                            ex_state_q <= EX_HOLD;
                        end else begin
                            exp_cnt_q <= exp_cnt_q - 16'h0001;
                        end
                    end
                end
                EX_HOLD: begin
                    if (rd_start) begin
                        if (!ext_mode && frames_left_q > 16'h0001) begin
                            frames_left_q <= frames_left_q - 16'h0001;
                            exp_cnt_q <= exp_len;
                            ex_state_q <= EX_RUN;
                        end else begin
                            frames_left_q <= 16'h0000;
                            ex_state_q <= EX_IDLE;
                        end
                    end
                end
                default: ex_state_q <= EX_IDLE;
            endcase
        end
    end

    // Readout sequencer: overhead, then bursts with a one-period gap each
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rd_state_q <= RD_IDLE;
            ovh_cnt_q <= 10'h000;
            pix_q <= 10'h000;
            burst_q <= 16'h0000;
        end else if (rd_start) begin
            rd_state_q <= RD_OVERHEAD;
            ovh_cnt_q <= OVERHEAD_PIX;
        end else if (pix_en) begin
            case (rd_state_q)
                RD_IDLE: rd_state_q <= RD_IDLE;
                RD_OVERHEAD: begin
                    if (ovh_cnt_q <= 10'h001) begin
                        rd_state_q <= RD_ROWS;
                        pix_q <= 10'h000;
                        burst_q <= 16'h0000;
                    end else begin
                        ovh_cnt_q <= ovh_cnt_q - 10'h001;
                    end
                end
                RD_ROWS: begin
                    if (pix_q == BURST_PIX) begin
                        pix_q <= 10'h000;
                        burst_q <= burst_q + 16'h0001;
                        if (rd_last) begin
                            rd_state_q <= RD_IDLE;
                        end
                    end else begin
                        pix_q <= pix_q + 10'h001;
                    end
                end
                default: rd_state_q <= RD_IDLE;
            endcase
        end
    end

    // Status word for the current pixel period
    always_comb begin
        ctrl_word = '0;
        ctrl_word.one = 1'b1;
        ctrl_word.pixel_valid = (rd_state_q == RD_ROWS) && (pix_q != BURST_PIX);
        ctrl_word.row_valid = (rd_state_q == RD_ROWS) && (pix_q != BURST_PIX);
        ctrl_word.frame_valid = (rd_state_q == RD_ROWS);
        ctrl_word.overhead = (rd_state_q == RD_OVERHEAD);
        ctrl_word.inte1 = (ex_state_q == EX_RUN);
        ctrl_word.inte2 = (ex_state_q == EX_RUN);
    end

    // Lane shifters, loaded at slot 0 so all lanes stay word-aligned
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            for (int l = 0; l < 16; l++) begin
                lane_sh_q[l] <= 12'h000;
            end
            ctrl_sh_q <= 12'h000;
        end else if (load_en) begin
            ctrl_sh_q <= ctrl_word;
            for (int l = 0; l < 16; l++) begin
                if (l >= 8 && lane8 && top_lane_off[l - 8]) begin
                    lane_sh_q[l] <= 12'h000;
                end else if (l >= 8 && lane8) begin
                    lane_sh_q[l] <= train_word;
                end else if (ctrl_word.pixel_valid) begin
                    // No pixel array here: a ramp of column, row and lane stands in
                    lane_sh_q[l] <= 12'(pix_q) + 12'(burst_q) + 12'(l);
                end else begin
                    lane_sh_q[l] <= train_word;
                end
            end
        end else begin
            ctrl_sh_q <= {1'b0, ctrl_sh_q[11:1]};
            for (int l = 0; l < 16; l++) begin
                lane_sh_q[l] <= {1'b0, lane_sh_q[l][11:1]};
            end
        end
    end

    // Lane bit 0 of each shifter drives the pins straight from flops
    always_comb begin
        for (int l = 0; l < 16; l++) begin
            data_lane_o[l] = lane_sh_q[l][0];
        end
    end

    assign control_lane_o = ctrl_sh_q[0];

    // DDR clock lane: word bit k leaves in slot k + 1, so odd slots are high
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            clock_lane_o <= 1'b0;
        end else begin
            clock_lane_o <= ~slot_q[0];
        end
    end

endmodule

//--- testbench/sensor_readout_props.sv
// Port-level assertions for the sensor readout block
`timescale 1ns/1ns
module sensor_readout_props (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic spi_clk_i,
    input wire logic spi_sel_i,
    input wire logic spi_in_i,
    input wire logic spi_out_full_o,
    input wire logic spi_out_part_o,
    input wire logic frame_request_i,
    input wire logic exposure_trigger_i,
    input wire logic [15:0] data_lane_o,
    input wire logic control_lane_o,
    input wire logic clock_lane_o
);
    logic [3:0] slot_q;
    logic lock_q;
    logic req_q;
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // Slot tracker; the first clock lane high after reset marks slot 0
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            slot_q <= 4'h0;
            lock_q <= 1'b0;
        end else if (lock_q || clock_lane_o) begin
            lock_q <= 1'b1;
            slot_q <= !lock_q ? 4'h1 : (slot_q == 4'hB ? 4'h0 : slot_q + 4'h1);
        end
    end
    // Remembers that a frame was ever requested
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            req_q <= 1'b0;
        end else if (frame_request_i) begin
            req_q <= 1'b1;
        end
    end
    chk_clk_phase: assert property (lock_q |-> clock_lane_o == !slot_q[0])
        else $error("clock lane out of phase");
    chk_ctrl_marker: assert property (lock_q && slot_q == 4'h9 |-> control_lane_o)
        else $error("control word bit 9 low");
    chk_ctrl_zeros: assert property (
        lock_q && (slot_q inside {4'h3, 4'h4, 4'h8, 4'hA, 4'hB}) |-> !control_lane_o)
        else $error("control word zero bit high");
    chk_valid_nest: assert property (
        lock_q && slot_q == 4'h0 && control_lane_o |=> control_lane_o ##1 control_lane_o)
        else $error("pixel valid without row and frame valid");
    chk_frame_cause: assert property (
        lock_q && slot_q == 4'h2 && control_lane_o |-> req_q)
        else $error("frame valid without request");
    chk_sel_clear: assert property (
        !spi_sel_i [*5] |-> !spi_out_full_o && !spi_out_part_o)
        else $error("readback driven without select");
    chk_part_subset: assert property (spi_out_part_o |-> spi_out_full_o)
        else $error("partial readback differs from full");
    chk_out_hold: assert property (
        (spi_clk_i && spi_sel_i) [*6] |=> $stable(spi_out_full_o) && $stable(spi_out_part_o))
        else $error("readback changed while serial clock high");
endmodule
bind sensor_readout sensor_readout_props u_props (.clock_i(clock_i), .srst_i(srst_i),
    .spi_clk_i(spi_clk_i), .spi_sel_i(spi_sel_i), .spi_in_i(spi_in_i),
    .spi_out_full_o(spi_out_full_o), .spi_out_part_o(spi_out_part_o),
    .frame_request_i(frame_request_i), .exposure_trigger_i(exposure_trigger_i),
    .data_lane_o(data_lane_o), .control_lane_o(control_lane_o), .clock_lane_o(clock_lane_o));

//--- testbench/lane_receiver.sv
// Host-side lane receiver: word alignment and deserialisation
`timescale 1ns/1ns
module lane_receiver
    import sensor_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic control_lane_i,
    input wire logic [15:0] data_lane_i,
    output logic word_o,
    output ctrl_word_t ctrl_o,
    output logic [15:0][11:0] data_o
);
    logic [11:0] csh_q;
    logic [15:0][11:0] dsh_q;
    logic lock_q;
    logic [3:0] cnt_q;
    // Shift in LSB first, so the oldest bit ends in bit 0
    always_ff @(posedge clock_i) begin
        csh_q <= {control_lane_i, csh_q[11:1]};
        for (int l = 0; l < 16; l++) begin
            dsh_q[l] <= {data_lane_i[l], dsh_q[l][11:1]};
        end
    end
    // Lock on the idle word; only it has a single one, so no false lock
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            lock_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (!lock_q) begin
            // Shifter starts unknown; a case compare keeps lock from going unknown
            lock_q <= ({control_lane_i, csh_q[11:1]} === 12'h200);
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= (cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
        end
    end
    // Hand out a whole word every twelve slots
    always_ff @(posedge clock_i) begin
        word_o <= lock_q && cnt_q == 4'hB;
        if (lock_q && cnt_q == 4'hB) begin
            ctrl_o <= {control_lane_i, csh_q[11:1]};
            for (int l = 0; l < 16; l++) begin
                data_o[l] <= {data_lane_i[l], dsh_q[l][11:1]};
            end
        end
    end
endmodule

//--- testbench/sensor_readout_tb.sv
// Self-checking bench for the sensor readout block
`timescale 1ns/1ns
module sensor_readout_tb
    import sensor_pkg::*;
;
    localparam int H = 6;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic spi_clk_i = 1'b0;
    logic spi_sel_i = 1'b0;
    logic spi_in_i = 1'b0;
    logic frame_request_i = 1'b0;
    logic exposure_trigger_i = 1'b0;
    logic spi_out_full_o, spi_out_part_o, control_lane_o, clock_lane_o, word_o;
    logic [15:0] data_lane_o;
    ctrl_word_t ctrl_o;
    logic [15:0][11:0] data_o;
    logic [7:0] rdf, rdp;
    logic [7:0] pd = 8'h00;
    logic [11:0] trn = TRAIN_RST;
    logic lane8 = 1'b0;
    int bad_count = 0, checked = 0, npix, nfot, ninte, nlane, follow;

    // Free-running 100 MHz clock
    always #5 clock_i = ~clock_i;

    sensor_readout u_dut (.clock_i(clock_i), .srst_i(srst_i), .spi_clk_i(spi_clk_i),
        .spi_sel_i(spi_sel_i), .spi_in_i(spi_in_i), .spi_out_full_o(spi_out_full_o),
        .spi_out_part_o(spi_out_part_o), .frame_request_i(frame_request_i),
        .exposure_trigger_i(exposure_trigger_i), .data_lane_o(data_lane_o),
        .control_lane_o(control_lane_o), .clock_lane_o(clock_lane_o));
    lane_receiver u_rx (.clock_i(clock_i), .srst_i(srst_i), .control_lane_i(control_lane_o),
        .data_lane_i(data_lane_o), .word_o(word_o), .ctrl_o(ctrl_o), .data_o(data_o));

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic results();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One group MSB first; data changes only while the serial clock is low
    // Serial clock of 125 ns, under the advised readback limit
    task automatic group(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            spi_clk_i = 1'b0;
            spi_in_i = w[i];
            #62;
            spi_clk_i = 1'b1;
            rdf = {rdf[6:0], spi_out_full_o};
            rdp = {rdp[6:0], spi_out_part_o};
            #63;
        end
    endtask
    // Select leads by half a period and trails by a full one
    task automatic xfer(input logic [15:0] a, input logic [15:0] b, input bit two);
        spi_sel_i = 1'b1;
        group(a);
        if (two) group(b);
        spi_clk_i = 1'b0;
        cyc(2 * H);
        spi_sel_i = 1'b0;
        cyc(2 * H);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        xfer({1'b1, a, d}, 16'h0000, 1'b0);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] f, input logic [7:0] p);
        xfer({1'b0, a, 8'h00}, 16'h0000, 1'b0);
        chk({8'h00, rdf}, {8'h00, f});
        chk({8'h00, rdp}, {8'h00, p});
    endtask
    task automatic pulse(input bit trig);
        if (trig) exposure_trigger_i = 1'b1;
        else frame_request_i = 1'b1;
        cyc(6);
        exposure_trigger_i = 1'b0;
        frame_request_i = 1'b0;
    endtask
    // Tally n words; idle or switched-off lanes must show training or zero
    task automatic watch(input int n);
        int g;
        logic pv;
        logic tail;
        pv = 1'b0;
        tail = 1'b0;
        npix = 0;
        nfot = 0;
        ninte = 0;
        nlane = 0;
        follow = -1;
        for (int k = 0; k < n; k++) begin
            g = 0;
            while (word_o !== 1'b1) begin
                cyc(1);
                g++;
                if (g > 30) begin
                    bad_count++;
                    $display("ERROR t=%0t no lane word", $time);
                    results();
                end
            end
            npix += ctrl_o.pixel_valid;
            nfot += ctrl_o.overhead;
            if (ctrl_o.pixel_valid && (ctrl_o.inte1 || ctrl_o.inte2)) ninte++;
            if (tail && follow < 0) follow = ctrl_o.overhead;
            tail = pv && !ctrl_o.pixel_valid;
            pv = ctrl_o.pixel_valid;
            for (int l = 0; l < 16; l++) begin
                if (lane8 && l >= 8 && pd[l - 8]) begin
                    if (data_o[l] !== 12'h000) nlane++;
                end else if (!ctrl_o.pixel_valid || (lane8 && l >= 8)) begin
                    if (data_o[l] !== trn) nlane++;
                end
            end
            cyc(1);
        end
    endtask
    // Idle lanes: marker-only control word, training word everywhere
    task automatic t_idle();
        watch(4);
        chk({4'h0, ctrl_o}, 16'h0200);
        chk(nlane, 0);
    endtask
    // Defaults, read-only status, burst write, partial range edges
    task automatic t_regs();
        rd(FRAMES_LO_ADDR, 8'h01, 8'h00);
        rd(ROWS_HI_ADDR, 8'h0F, 8'h00);
        wr(STATUS_ADDR, 8'hFF);
        rd(STATUS_ADDR, 8'h09, 8'h09);
        xfer({1'b1, PART_LAST_ADDR, 8'hA5}, {1'b1, 7'h66, 8'h3C}, 1'b1);
        wr(PART_FIRST_ADDR, 8'h5A);
        rd(PART_LAST_ADDR, 8'hA5, 8'hA5);
        rd(7'h66, 8'h3C, 8'h00);
        rd(PART_FIRST_ADDR, 8'h5A, 8'h5A);
    endtask
    // Two internal frames of two rows, exposure longer than the overhead
    task automatic t_internal();
        wr(EXP_LO_ADDR, 8'h14);
        wr(EXP_HI_ADDR, 8'h00);
        wr(ROWS_LO_ADDR, 8'h02);
        wr(ROWS_HI_ADDR, 8'h00);
        wr(FRAMES_LO_ADDR, 8'h02);
        pulse(1'b0);
        watch(1400);
        chk(npix, 1280);
        chk(nfot, 16);
        chk(ninte > 0, 1);
        chk(follow, 1);
        chk(nlane, 0);
    endtask
    // Eight lanes, four top lanes off, new training word
    task automatic t_lane8();
        wr(TRAIN_LO_ADDR, 8'hA5);
        wr(TRAIN_HI_ADDR, 8'h03);
        wr(LANE_MODE_ADDR, 8'h01);
        wr(LANE_PD0_ADDR, 8'h0F);
        wr(FRAMES_LO_ADDR, 8'h01);
        trn = 12'h3A5;
        lane8 = 1'b1;
        pd = 8'h0F;
        pulse(1'b0);
        watch(1400);
        chk(npix, 1280);
        chk(nlane, 0);
    endtask
    // External mode: trigger starts exposure, request starts readout
    task automatic t_external();
        wr(LANE_MODE_ADDR, 8'h00);
        wr(LANE_PD0_ADDR, 8'h00);
        wr(EXP_SRC_ADDR, 8'h01);
        lane8 = 1'b0;
        pd = 8'h00;
        pulse(1'b1);
        rd(STATUS_ADDR, 8'h0A, 8'h0A);
        pulse(1'b0);
        watch(700);
        chk(npix, 640);
        chk(nlane, 0);
    endtask

    // Reset for four cycles, then the scenarios in turn
    initial begin
        cyc(4);
        srst_i = 1'b0;
        cyc(4);
        t_idle();
        t_regs();
        t_internal();
        t_lane8();
        t_external();
        results();
    end
endmodule
